// ==== core/spwm_top.sv ====
// three-timer, three-unit standard pwm generator with wishbone registers
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "spwm_consts.svh"
module spwm_top (
    input  wire logic                  MCLK_I,
    input  wire logic                  NRST_I,
    input  wire logic                  SLEEP_I,
    input  wire logic                  WB_CYC_I,
    input  wire logic                  WB_STB_I,
    input  wire logic                  WB_WE_I,
    input  wire logic [3:0]            WB_ADR_I,
    input  wire logic [3:0]            WB_SEL_I,
    input  wire logic [31:0]           WB_DAT_I,
    output logic      [31:0]           WB_DAT_O,
    output logic                       WB_ACK_O,
    output logic      [2:0]            PWM_O,
    output logic      [2:0]            PWM_OE_O
);
    import spwm_pkg::*;
    localparam int NT = `SPWM_NTIMERS;
    localparam int NU = `SPWM_NUNITS;

    // bus register map: offsets are word indices, byte address = 4*index
    logic [7:0]   period_q [NT];
    spwm_tctrl_t  tctrl_q  [NT];
    logic [7:0]   duty_high_q [NU];
    spwm_uctrl_t  uctrl_q  [NU];
    logic [1:0]   tsel_q   [NU];
    logic [2:0]   pindir_q;
    logic         ack_q;
    logic [31:0]  rdat_q;
    // timer state
    logic [7:0]   count_q [NT], count_d [NT];
    logic [3:0]   pre_q   [NT], pre_d   [NT];
    logic [1:0]   phase_q [NT], phase_d [NT];
    logic [NT-1:0] flag_q, flag_d, tick, wrap;
    // unit state
    logic [9:0]   shadow_q [NU], shadow_d [NU];
    logic [NU-1:0] out_q, out_d, ena_q, ena_d;
    logic [2:0]   pwm_d, oe_d;

    spwm_req_t    req;
    logic         acc, wr;
    logic [1:0]   bank;
    assign req  = '{adr: WB_ADR_I, we: WB_WE_I, dat: WB_DAT_I[7:0]};
    assign acc  = WB_CYC_I && WB_STB_I && !ack_q;
    // a write lands at the edge that samples ack high; the master
    // holds the request until that edge
    assign wr   = WB_CYC_I && WB_STB_I && ack_q && req.we && WB_SEL_I[0];
    assign bank = WB_DAT_I[9:8];

    function automatic logic [3:0] pre_max(input logic [1:0] ps);
        case (ps)
            `SPWM_PS_4:  pre_max = `SPWM_PS_MAX4;
            `SPWM_PS_16: pre_max = `SPWM_PS_MAX16;
            default:     pre_max = 4'h0;
        endcase
    endfunction : pre_max

    function automatic logic [1:0] frac(input logic [1:0] ps,
                                        input logic [1:0] ph,
                                        input logic [3:0] pr);
        // clock phase at 1:1, else top prescaler bits
        case (ps)
            `SPWM_PS_1:  frac = ph;
            `SPWM_PS_4:  frac = pr[1:0];
            default:     frac = pr[3:2];
        endcase
    endfunction : frac

    // timers; a timer's fractional base counts one step per prescaled clock
    always_comb begin
        for (int t = 0; t < NT; t++) begin
            count_d[t] = count_q[t];
            pre_d[t]   = pre_q[t];
            phase_d[t] = phase_q[t];
            flag_d[t]  = flag_q[t];
            tick[t]    = 1'b0;
            wrap[t]    = 1'b0;
            if (tctrl_q[t].run && !SLEEP_I) begin
                // clock phase is the innermost stage, so the prescaler
                // bits step once per four clocks and form the fraction at 4:1 and 16:1
                phase_d[t] = phase_q[t] + 2'h1;
                if (phase_q[t] == 2'h3) begin
                    // prescale only, postscale ignored
                    // >= so a ratio lowered mid-count cannot overrun
                    if (pre_q[t] >= pre_max(tctrl_q[t].prescale)) begin
                        pre_d[t] = 4'h0;
                        tick[t]  = 1'b1;
                    end else begin
                        pre_d[t] = pre_q[t] + 4'h1;
                    end
                end
                if (tick[t]) begin
                    if (count_q[t] == period_q[t]) begin
                        count_d[t] = 8'h00;
                        wrap[t]    = 1'b1;
                    end else begin
                        count_d[t] = count_q[t] + 8'h01;
                    end
                end
            end
            if (wr && req.adr == `SPWM_ADR_FLAGS && req.dat[t])
                flag_d[t] = 1'b0;
            if (wrap[t])
                flag_d[t] = 1'b1;
        end
    end

    // units
    always_comb begin
        logic [1:0] s;
        logic [9:0] base;
        logic [9:0] duty;
        s = 2'h0;
        base = 10'h000;
        duty = 10'h000;
        for (int u = 0; u < NU; u++) begin
            shadow_d[u] = shadow_q[u];
            out_d[u]    = out_q[u];
            ena_d[u]    = ena_q[u];
            s = (tsel_q[u] < 2'h3) ? tsel_q[u] : 2'h0;
            // ten-bit base
            // base about to be entered, so the pin falls on the very
            // edge at which the base reaches the duty value
            base = {count_d[s],
                    frac(tctrl_q[s].prescale, phase_d[s], pre_d[s])};
            duty = {duty_high_q[u], uctrl_q[u].low_bits};
            if (uctrl_q[u].mode == `SPWM_MODE_PWM) begin
                if (wrap[s] && tick[s]) begin
                    shadow_d[u] = duty;
                    out_d[u]    = (duty != 10'h000);
                    ena_d[u]    = 1'b1;
                end else if (ena_q[u] && base == shadow_q[u]
                             && !SLEEP_I) begin
                    out_d[u] = 1'b0;
                end
            end else begin
                out_d[u] = 1'b0;
                ena_d[u] = 1'b0;
            end
        end
    end

    // pin gated by direction and unit activity
    always_comb begin
        for (int u = 0; u < NU; u++) begin
            oe_d[u]  = !pindir_q[u] && (uctrl_q[u] != '0);
            pwm_d[u] = oe_d[u] && out_d[u];
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            for (int t = 0; t < NT; t++) begin
                count_q[t] <= 8'h00;
                pre_q[t]   <= 4'h0;
                phase_q[t] <= 2'h0;
            end
            for (int u = 0; u < NU; u++)
                shadow_q[u] <= 10'h000;
            flag_q   <= '0;
            out_q    <= '0;
            ena_q    <= '0;
            PWM_O    <= 3'h0;
            PWM_OE_O <= 3'h0;
        end else begin
            count_q  <= count_d;
            pre_q    <= pre_d;
            phase_q  <= phase_d;
            shadow_q <= shadow_d;
            flag_q   <= flag_d;
            out_q    <= out_d;
            ena_q    <= ena_d;
            PWM_O    <= pwm_d;
            PWM_OE_O <= oe_d;
        end
    end

    // registers; bits 9:8 of write data pick timer or unit index
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            for (int t = 0; t < NT; t++) begin
                period_q[t] <= `SPWM_PERIOD_RST;
                tctrl_q[t]  <= '0;
            end
            for (int u = 0; u < NU; u++) begin
                duty_high_q[u] <= 8'h00;
                uctrl_q[u]     <= '0;
                tsel_q[u]      <= 2'h0;
            end
            pindir_q <= `SPWM_PINDIR_RST;
            ack_q    <= 1'b0;
            rdat_q   <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            if (wr && bank < 2'h3) begin
                case (req.adr)
                    `SPWM_ADR_PERIOD: period_q[bank] <= req.dat;
                    `SPWM_ADR_TCTRL:  tctrl_q[bank]  <= req.dat[6:0];
                    `SPWM_ADR_DUTYH:  duty_high_q[bank] <= req.dat;
                    `SPWM_ADR_UCTRL:  uctrl_q[bank]  <= req.dat[5:0];
                    `SPWM_ADR_TSEL: begin
                        tsel_q[0] <= req.dat[1:0];
                        tsel_q[1] <= req.dat[3:2];
                        tsel_q[2] <= req.dat[5:4];
                    end
                    `SPWM_ADR_PINDIR: pindir_q <= req.dat[2:0];
                    default: ;
                endcase
            end
            if (acc) begin
                rdat_q <= 32'h0000_0000;
                case (req.adr)
                    `SPWM_ADR_SHADOW:
                        rdat_q <= {8'h00, shadow_q[2][9:2], shadow_q[1][9:2],
                                   shadow_q[0][9:2]};
                    `SPWM_ADR_COUNT:
                        rdat_q <= {8'h00, count_q[2], count_q[1],
                                   count_q[0]};
                    `SPWM_ADR_FLAGS: rdat_q <= {29'h0, flag_q};
                    `SPWM_ADR_PERIOD:
                        rdat_q <= {8'h00, period_q[2], period_q[1],
                                   period_q[0]};
                    `SPWM_ADR_DUTYH:
                        rdat_q <= {8'h00, duty_high_q[2], duty_high_q[1],
                                   duty_high_q[0]};
                    `SPWM_ADR_UCTRL:
                        rdat_q <= {10'h0, uctrl_q[2], 2'h0, uctrl_q[1],
                                   2'h0, uctrl_q[0]};
                    `SPWM_ADR_TCTRL:
                        rdat_q <= {9'h0, tctrl_q[2], 1'h0, tctrl_q[1],
                                   1'h0, tctrl_q[0]};
                    `SPWM_ADR_TSEL:
                        rdat_q <= {26'h0, tsel_q[2], tsel_q[1], tsel_q[0]};
                    `SPWM_ADR_PINDIR: rdat_q <= {29'h0, pindir_q};
                    default: rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdat_q;

    // flag rises one cycle after a wrap
    a_flag_on_wrap: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        wrap[0] |=> flag_q[0]) else $error("match flag not set");
    a_sleep_freeze: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        SLEEP_I |=> $stable(count_q[0])) else $error("count moved in sleep");
    a_pin_dir_gate: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        pindir_q[0] |=> !PWM_OE_O[0]) else $error("pin driven as input");
    a_release_pin: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (uctrl_q[0] == '0) |=> !PWM_OE_O[0]) else $error("pin not released");
    a_zero_duty: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (wrap[0] && shadow_d[0] == 10'h000 && tsel_q[0] == 2'h0)
        |=> !out_q[0]) else $error("pin set at zero duty");
    a_shadow_hold: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        (!wrap[0] && tsel_q[0] == 2'h0) |=> $stable(shadow_q[0]))
        else $error("shadow changed mid period");
    a_count_clear: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        wrap[0] |=> count_q[0] == 8'h00) else $error("count not cleared");
    // prescaler restarts at every timer step
    a_pre_bound: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
        tick[0] |=> (pre_q[0] == 4'h0 && phase_q[0] == 2'h0))
        else $error("prescaler overrun");
endmodule : spwm_top

// ==== core/spwm_consts.svh ====
// constants for the standard pwm generator
`ifndef SPWM_CONSTS_SVH
`define SPWM_CONSTS_SVH
`define SPWM_ADR_PERIOD   4'h0
`define SPWM_ADR_TCTRL    4'h1
`define SPWM_ADR_DUTYH    4'h2
`define SPWM_ADR_UCTRL    4'h3
`define SPWM_ADR_SHADOW   4'h4
`define SPWM_ADR_TSEL     4'h5
`define SPWM_ADR_COUNT    4'h6
`define SPWM_ADR_FLAGS    4'h7
`define SPWM_ADR_PINDIR   4'h8
`define SPWM_PERIOD_RST   8'hFF
`define SPWM_PINDIR_RST   3'h7
`define SPWM_PS_1         2'h0
`define SPWM_PS_4         2'h1
`define SPWM_PS_16        2'h2
`define SPWM_PS_MAX4      4'h3
`define SPWM_PS_MAX16     4'hF
`define SPWM_MODE_PWM     4'hC
`define SPWM_NTIMERS      3
`define SPWM_NUNITS       3
`endif

// ==== core/spwm_pkg.sv ====
// types for the standard pwm generator
package spwm_pkg;
    typedef struct packed {
        logic [3:0] adr;
        logic       we;
        logic [7:0] dat;
    } spwm_req_t;
    typedef struct packed {
        logic [3:0] postscale;
        logic       run;
        logic [1:0] prescale;
    } spwm_tctrl_t;
    typedef struct packed {
        logic [1:0] low_bits;
        logic [3:0] mode;
    } spwm_uctrl_t;
endpackage : spwm_pkg

// ==== testbench/spwm_load.sv ====
// load model: resolves the pwm pins and times unit 0
`timescale 1ns/1ps
module spwm_load (
    input  wire logic       clk_i,
    input  wire logic [2:0] pwm_i,
    input  wire logic [2:0] oe_i,
    output logic      [2:0] pin_o,
    output int              per_o,
    output int              rise_o
);
    int   since;
    logic last;
    // level reaches pin only when driven
    // undriven pin falls to the load's pull-down, not the last level
    assign pin_o = pwm_i & oe_i;
    initial begin
        since  = 0;
        per_o  = 0;
        rise_o = 0;
        last   = 1'b0;
    end
    // rise-to-rise spacing gives the period
    always @(posedge clk_i) begin
        since++;
        if (pin_o[0] === 1'b1 && last !== 1'b1) begin
            per_o  <= since;
            rise_o <= rise_o + 1;
            since  = 0;
        end
        last = pin_o[0];
    end
endmodule : spwm_load

// ==== testbench/testbench.sv ====
// self-checking bench for the standard pwm generator
`timescale 1ns/1ps
`include "spwm_consts.svh"
module testbench;
    import spwm_pkg::*;
    logic        mclk, nrst, sleep, cyc, stb, we, ack;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, r, c0;
    logic [2:0]  pwm, oe, pin;
    int          per, rises, err_count, check_count;
    int          p, q, duty, ratio, hi, n;
    spwm_tctrl_t tc;
    spwm_uctrl_t uc;

    spwm_top dut_u (.MCLK_I(mclk), .NRST_I(nrst), .SLEEP_I(sleep),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .PWM_O(pwm), .PWM_OE_O(oe));
    spwm_load load_u (.clk_i(mclk), .pwm_i(pwm), .oe_i(oe), .pin_o(pin),
        .per_o(per), .rise_o(rises));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task report_and_stop;
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    // one classic cycle; request held until ack is sampled
    task automatic wb(input logic [3:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] rd_v);
        int k;
        k = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_count++;
            report_and_stop;
        end
        rd_v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        // write lands at the ack edge; registered pins follow one later
        repeat (2) @(posedge mclk);
    endtask : wb

    task automatic wr(input logic [3:0] a, input logic [1:0] i,
                      input logic [7:0] d);
        logic [31:0] x;
        wb(a, 1'b1, {22'h0, i, d}, x);
    endtask : wr

    task automatic watch(input int cyc_n, output int h);
        h = 0;
        repeat (cyc_n) begin
            @(posedge mclk);
            if (pin[0] === 1'b1) h++;
        end
    endtask : watch

    // behavioural model of unit 0: period and high time in clocks
    task automatic expect_wave(input int pv, input int d, input int rt);
        repeat (2 * (pv + 1) * 4 * rt + 20) @(posedge mclk);
        chk("period", per, (pv + 1) * 4 * rt);
        watch((pv + 1) * 4 * rt, hi);
        chk("high time", hi, d * rt);
    endtask : expect_wave

    initial begin
        {nrst, sleep, cyc, stb, we} = 5'h0;
        adr = 4'h0;
        sel = 4'h1;
        wdat = 32'h0;
        err_count = 0;
        check_count = 0;
        void'($urandom(89));
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        wb(`SPWM_ADR_PERIOD, 1'b0, 32'h0, r);
        chk("period reset", r, 32'h00ff_ffff);
        wb(`SPWM_ADR_PINDIR, 1'b0, 32'h0, r);
        chk("pindir reset", r, 32'h0000_0007);
        chk("oe reset", {29'h0, oe}, 32'h0);
        wb(4'h9, 1'b0, 32'h0, r);
        chk("unmapped", r, 32'h0);
        p = 8 + $urandom % 8;
        duty = 1 + $urandom % (4 * (p + 1) - 1);
        uc = '{low_bits: duty[1:0], mode: `SPWM_MODE_PWM};
        wr(`SPWM_ADR_PINDIR, 2'h0, 8'h07);
        wr(`SPWM_ADR_PERIOD, 2'h0, p[7:0]);
        wr(`SPWM_ADR_UCTRL, 2'h0, {2'h0, uc});
        wr(`SPWM_ADR_DUTYH, 2'h0, duty[9:2]);
        wr(`SPWM_ADR_TSEL, 2'h0, 8'h00);
        wr(`SPWM_ADR_FLAGS, 2'h0, 8'h01);
        for (int i = 0; i < 3; i++) begin
            ratio = 1 << (2 * i);
            tc = '{postscale: 4'($urandom), run: 1'b1, prescale: i[1:0]};
            wr(`SPWM_ADR_TCTRL, 2'h0, {1'b0, tc});
            if (i == 0) begin
                n = 0;
                do begin
                    wb(`SPWM_ADR_FLAGS, 1'b0, 32'h0, r);
                    n++;
                end while (r[0] !== 1'b1 && n < 100);
                chk("match flag", r[0], 1'b1);
                wr(`SPWM_ADR_PINDIR, 2'h0, 8'h06);
                chk("oe on", oe[0], 1'b1);
            end
            expect_wave(p, duty, ratio);
        end
        q = p + 3;
        wr(`SPWM_ADR_PERIOD, 2'h1, q[7:0]);
        wr(`SPWM_ADR_TCTRL, 2'h1, 8'h04);
        wr(`SPWM_ADR_TSEL, 2'h0, 8'h01);
        expect_wave(q, duty, 1);
        wr(`SPWM_ADR_TSEL, 2'h0, 8'h00);
        n = rises;
        for (int k = 0; k < 3000 && rises == n; k++) @(posedge mclk);
        if (rises == n) begin
            err_count++;
            report_and_stop;
        end
        wr(`SPWM_ADR_DUTYH, 2'h0, 8'h02);
        wb(`SPWM_ADR_SHADOW, 1'b0, 32'h0, r);
        chk("shadow held", r[7:0], duty[9:2]);
        wr(`SPWM_ADR_SHADOW, 2'h0, 8'h5a);
        expect_wave(p, {8'h02, duty[1:0]}, 16);
        wb(`SPWM_ADR_SHADOW, 1'b0, 32'h0, r);
        chk("shadow ro", r[7:0], 8'h02);
        wr(`SPWM_ADR_DUTYH, 2'h0, 8'h00);
        wr(`SPWM_ADR_UCTRL, 2'h0, 8'h0c);
        expect_wave(p, 0, 16);
        wr(`SPWM_ADR_DUTYH, 2'h0, 8'hff);
        wr(`SPWM_ADR_UCTRL, 2'h0, 8'h3c);
        repeat (2 * (p + 1) * 64 + 20) @(posedge mclk);
        watch((p + 1) * 64, hi);
        chk("over duty", hi, (p + 1) * 64);
        sleep <= 1'b1;
        wb(`SPWM_ADR_COUNT, 1'b0, 32'h0, c0);
        n = pin[0];
        repeat (300) @(posedge mclk);
        wb(`SPWM_ADR_COUNT, 1'b0, 32'h0, r);
        chk("frozen count", r, c0);
        chk("frozen pin", pin[0], n[0]);
        wr(`SPWM_ADR_FLAGS, 2'h0, 8'h01);
        wb(`SPWM_ADR_FLAGS, 1'b0, 32'h0, r);
        chk("flag clear", r[0], 1'b0);
        sleep <= 1'b0;
        wr(`SPWM_ADR_PINDIR, 2'h0, 8'h07);
        chk("oe input", oe[0], 1'b0);
        wr(`SPWM_ADR_PINDIR, 2'h0, 8'h06);
        wr(`SPWM_ADR_UCTRL, 2'h0, 8'h00);
        chk("oe released", oe[0], 1'b0);
        report_and_stop;
    end
endmodule : testbench
